// ### dv/card_clock_divider_assertions.sv
// Port checks for the card clock divider
`timescale 1ns/1ps
module card_clock_divider_assertions (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Host select pin
  input wire select_n,
  // Card side and status
  input wire card_clock_out,
  input wire card_reset_out,
  input wire slow_edge_select,
  input wire fast_edge_select,
  input wire [1:0] card_supply,
  input wire ratio_pending,
  input wire [1:0] active_ratio
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Input clock is 5 clocks high, 5 low, so one pulse is 10 clocks
  sequence div1_cycle; ##3 card_clock_out ##4 !card_clock_out; endsequence
  sequence div2_cycle; ##8 card_clock_out ##4 !card_clock_out; endsequence
  sequence div4_cycle; ##18 card_clock_out ##4 !card_clock_out; endsequence
  a_edge_exclusive: assert property (slow_edge_select ^ fast_edge_select)
    else $error("edge selects not exclusive");
  a_stop_low: assert property (active_ratio == 2'h0 && $past(active_ratio) == 2'h0
    |-> !card_clock_out) else $error("card clock not held low");
  a_quiet_select: assert property ($changed({card_reset_out, card_supply, fast_edge_select})
    || $rose(ratio_pending) |-> select_n) else $error("command applied inside frame");
  a_pending_bound: assert property ($rose(ratio_pending) |-> ##[1:80] !ratio_pending)
    else $error("ratio change too late");
  a_ratio_switch: assert property ($changed(active_ratio) |-> $fell(ratio_pending))
    else $error("ratio changed without pending");
  a_div1_shape: assert property ($rose(card_clock_out) && active_ratio == 2'h1 |-> div1_cycle)
    else $error("ratio one shape wrong");
  a_div2_shape: assert property ($rose(card_clock_out) && active_ratio == 2'h2 |-> div2_cycle)
    else $error("ratio two shape wrong");
  a_div4_shape: assert property ($rose(card_clock_out) && active_ratio == 2'h3 |-> div4_cycle)
    else $error("ratio four shape wrong");
endmodule // card_clock_divider_assertions

// ### dv/host_serial_model.sv
// Host side of the serial command port
`timescale 1ns/1ps
module host_serial_model (
  // Clock
  input wire clock,
  // Serial command pins
  output reg select_n,
  output reg serial_clock,
  output reg serial_data
);
  initial begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data = 1'b0;
  end
  // Six clocks a level, above the five the synchronisers need
  task hold;
    repeat (6) @(negedge clock);
  endtask
  task open_frame;
    select_n = 1'b0;
    hold;
  endtask
  task send_byte(input [7:0] value);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      serial_data = value[i];
      hold;
      serial_clock = 1'b1;
      hold;
      serial_clock = 1'b0;
    end
    hold;
  endtask
  // Serial clock stays still and data is scrambled once deselected
  task close_frame;
    select_n = 1'b1;
    serial_data = ~serial_data;
    hold;
  endtask
endmodule // host_serial_model

// ### dv/tb_card_clock_divider.sv
// Self-checking bench for the card clock divider
`timescale 1ns/1ps
module tb_card_clock_divider;
  reg clock;
  reg rst;
  reg input_clock;
  reg [1:0] code;
  wire select_n, serial_clock, serial_data, card_clock_out, card_reset_out;
  wire slow_edge_select, fast_edge_select, ratio_pending;
  wire [1:0] card_supply;
  wire [1:0] active_ratio;
  wire [7:0] state = {1'b0, card_reset_out, card_supply, active_ratio, slow_edge_select,
    fast_edge_select};
  integer num_errors;
  integer cmp_count;
  integer i;
  reg [7:0] rises;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // 80 ns input clock keeps even ratio one under the card maximum
  initial begin
    input_clock = 1'b0;
    forever begin
      repeat (5) @(negedge clock);
      input_clock = ~input_clock;
    end
  end
  host_serial_model host_serial_model_inst (.clock(clock), .select_n(select_n),
    .serial_clock(serial_clock), .serial_data(serial_data));
  card_clock_divider card_clock_divider_inst (.clock(clock), .rst(rst), .select_n(select_n),
    .serial_clock(serial_clock), .serial_data(serial_data), .input_clock(input_clock),
    .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
    .slow_edge_select(slow_edge_select), .fast_edge_select(fast_edge_select),
    .card_supply(card_supply), .ratio_pending(ratio_pending), .active_ratio(active_ratio));
  ////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task compare(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Window is a whole number of periods for every ratio, so the count is exact
  task count_rises(output [7:0] n);
    reg last;
    begin
      n = 8'h00;
      last = card_clock_out;
      repeat (160) begin
        @(negedge clock);
        if (card_clock_out && !last) n = n + 8'h01;
        last = card_clock_out;
      end
    end
  endtask
  // Wait covers four input pulses plus synchroniser lag
  task command(input [7:0] value);
    host_serial_model_inst.open_frame;
    host_serial_model_inst.send_byte(value);
    host_serial_model_inst.close_frame;
    repeat (100) @(negedge clock);
  endtask
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    code = 2'h0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    compare(state, 8'h02);
    for (i = 0; i < 4; i = i + 1) begin
      code = i[1:0] + 2'h1;
      command({3'h0, i[0], code, i[1:0]});
      compare(state, {1'b0, i[0], i[1:0], code, 2'h2});
      compare({7'h00, ratio_pending}, 8'h00);
      count_rises(rises);
      compare(rises, (code == 2'h0) ? 8'h00 : (8'h20 >> code));
    end
    command(8'hC1);
    compare(state, 8'h71);
    command(8'h3F);
    compare(state, 8'h71);
    host_serial_model_inst.open_frame;
    host_serial_model_inst.send_byte(8'h07);
    host_serial_model_inst.send_byte(8'h1A);
    host_serial_model_inst.close_frame;
    repeat (100) @(negedge clock);
    compare(state, 8'h69);
    command(8'hC0);
    compare(state, 8'h6A);
    report_and_stop;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // tb_card_clock_divider
bind card_clock_divider card_clock_divider_assertions card_clock_divider_assertions_inst (
  .clock(clock), .rst(rst), .select_n(select_n), .card_clock_out(card_clock_out),
  .card_reset_out(card_reset_out), .slow_edge_select(slow_edge_select),
  .fast_edge_select(fast_edge_select), .card_supply(card_supply),
  .ratio_pending(ratio_pending), .active_ratio(active_ratio));

// ### verilog/card_clock_divider.v
// Smart card clock divider with serial command port, edge rate and card reset control
//
// What this block does
// - The clock control field is command bits B3:B2 and is only written after the select rising edge that ends a select-low frame.
// - The card clock is the input clock divided by one, two or four as the field selects.
// - The card clock leaves a final flip-flop so ratios two and four keep an even high and low time.
// - A new ratio takes effect within four input clock pulses, and the host waits that long.
// - At ratio one the input duty passes through uncorrected, so it must sit in 46 to 56 percent.
// - Slow or fast edge rate is set by command, independent of the division ratio.
// - Eight bits are shifted in and applied only on the select rising edge after a whole byte.
// - Bits arrive most significant first, so the address bits B7 to B5 lead the byte.
`timescale 1ns/1ps
`include "card_clock_regs.vh"

module card_clock_divider #(
  parameter [2:0] CHIP_ADDR = `RESET_CHIP_ADDR
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Host serial port pins
  input wire select_n,
  input wire serial_clock,
  input wire serial_data,
  // External input clock pin
  input wire input_clock,
  // Card side
  output reg card_clock_out,
  output reg card_reset_out,
  output reg slow_edge_select,
  output reg fast_edge_select,
  output reg [1:0] card_supply,
  // Status
  output reg ratio_pending,
  output reg [1:0] active_ratio
);

  localparam PIN_COUNT = 4;
  localparam PIN_SELECT = 0;
  localparam PIN_SCLK = 1;
  localparam PIN_DATA = 2;
  localparam PIN_INCLK = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted once stages two and three agree
  wire [PIN_COUNT-1:0] pins;
  reg [PIN_COUNT-1:0] pin_filtered;
  reg [PIN_COUNT-1:0] pin_previous;

  assign pins = {input_clock, serial_data, serial_clock, select_n};

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : sync
      reg stage1;
      reg stage2;
      reg stage3;
      always @(posedge clock) begin
        if (rst) begin
          stage1 <= (g == PIN_SELECT) ? 1'b1 : 1'b0;
          stage2 <= (g == PIN_SELECT) ? 1'b1 : 1'b0;
          stage3 <= (g == PIN_SELECT) ? 1'b1 : 1'b0;
          pin_filtered[g] <= (g == PIN_SELECT) ? 1'b1 : 1'b0;
          pin_previous[g] <= (g == PIN_SELECT) ? 1'b1 : 1'b0;
        end else begin
          stage1 <= pins[g];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            pin_filtered[g] <= stage3;
          end
          pin_previous[g] <= pin_filtered[g];
        end
      end
    end
  endgenerate

  wire select_fall = pin_previous[PIN_SELECT] & ~pin_filtered[PIN_SELECT];
  wire select_rise = ~pin_previous[PIN_SELECT] & pin_filtered[PIN_SELECT];
  wire select_active = ~pin_filtered[PIN_SELECT];
  wire sclk_rise = ~pin_previous[PIN_SCLK] & pin_filtered[PIN_SCLK];
  wire in_clock = pin_filtered[PIN_INCLK];
  wire in_rise = ~pin_previous[PIN_INCLK] & pin_filtered[PIN_INCLK];

  ////////////////////////////////////////////////////////////////////////////
  // Command capture
  wire [`CMD_WIDTH-1:0] command_byte;
  wire command_valid;

  command_shifter shifter (
    .clock(clock),
    .rst(rst),
    .select_fall(select_fall),
    .select_rise(select_rise),
    .serial_clock_rise(sclk_rise),
    .select_active(select_active),
    .serial_data(pin_filtered[PIN_DATA]),
    .command_byte(command_byte),
    .command_valid(command_valid)
  );

  wire [2:0] cmd_addr = command_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  wire cmd_normal = command_valid && (cmd_addr == CHIP_ADDR);
  wire cmd_edge = command_valid && (cmd_addr == `EDGE_RATE_ADDR);
  wire [1:0] cmd_clock = command_byte[`CMD_CLOCK_MSB:`CMD_CLOCK_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Command application
  reg [1:0] pending_ratio;

  always @(posedge clock) begin
    if (rst) begin
      pending_ratio <= `CLOCK_STOP;
      card_reset_out <= `RESET_CARD_RESET;
      card_supply <= `RESET_SUPPLY;
      fast_edge_select <= `RESET_FAST_EDGE;
      slow_edge_select <= ~`RESET_FAST_EDGE;
    end else begin
      if (cmd_normal) begin
        pending_ratio <= cmd_clock;
        card_reset_out <= command_byte[`CMD_RESET_BIT];
        card_supply <= command_byte[`CMD_SUPPLY_MSB:`CMD_SUPPLY_LSB];
      end
      if (cmd_edge) begin
        // Edge rate never touches the divider
        fast_edge_select <= command_byte[`CMD_EDGE_BIT];
        slow_edge_select <= ~command_byte[`CMD_EDGE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider: ratio changes only at the wrap of a four-pulse phase, or at any input rise while stopped
  reg [1:0] phase;
  reg [1:0] next_phase;
  reg [1:0] next_ratio;
  reg next_card_clock;
  reg wrap;

  always @* begin
    wrap = (phase == `PHASE_LAST) || (active_ratio == `CLOCK_STOP);
    next_phase = phase;
    next_ratio = active_ratio;
    if (in_rise) begin
      // Wrap bounds the switch delay to four input pulses
      next_phase = wrap ? `PHASE_FIRST : phase + `PHASE_STEP;
      next_ratio = wrap ? pending_ratio : active_ratio;
    end
    case (next_ratio)
      `CLOCK_STOP: next_card_clock = 1'b0;
      `CLOCK_DIV1: next_card_clock = in_clock;
      `CLOCK_DIV2: next_card_clock = in_rise ? ~next_phase[0] : card_clock_out;
      `CLOCK_DIV4: next_card_clock = in_rise ? ~next_phase[1] : card_clock_out;
      default: next_card_clock = 1'b0;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      phase <= `PHASE_LAST;
      active_ratio <= `CLOCK_STOP;
      card_clock_out <= 1'b0;
      ratio_pending <= 1'b0;
    end else begin
      phase <= next_phase;
      active_ratio <= next_ratio;
      // Output flop re-times ratios two and four for an even duty; ratio one follows the input duty
      card_clock_out <= next_card_clock;
      ratio_pending <= (pending_ratio != next_ratio);
    end
  end

endmodule // card_clock_divider

// ### verilog/card_clock_regs.vh
// Command byte layout, clock codes and reset values for the card clock divider
`ifndef CARD_CLOCK_REGS_VH
`define CARD_CLOCK_REGS_VH

// Command byte fields, most significant bit shifted first
`define CMD_WIDTH 8
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 5
`define CMD_RESET_BIT 4
`define CMD_CLOCK_MSB 3
`define CMD_CLOCK_LSB 2
`define CMD_SUPPLY_MSB 1
`define CMD_SUPPLY_LSB 0
`define CMD_EDGE_BIT 0

// Address that carries the edge rate command instead of a normal command
`define EDGE_RATE_ADDR 3'h6

// Card clock control codes
`define CLOCK_STOP 2'h0
`define CLOCK_DIV1 2'h1
`define CLOCK_DIV2 2'h2
`define CLOCK_DIV4 2'h3

// Divider phase: four input pulses per cycle of the slowest ratio
`define PHASE_LAST 2'h3
`define PHASE_FIRST 2'h0
`define PHASE_STEP 2'h1

// Bit counter of the command shifter
`define BIT_COUNT_LAST 3'h7
`define BIT_COUNT_ZERO 3'h0
`define BIT_COUNT_STEP 3'h1

// Reset values
`define RESET_SUPPLY 2'h0
`define RESET_CARD_RESET 1'h0
`define RESET_FAST_EDGE 1'h0
`define RESET_CHIP_ADDR 3'h0

`endif

// ### verilog/command_shifter.v
// Serial command shifter: gathers eight bits and presents them at chip select release
`timescale 1ns/1ps
`include "card_clock_regs.vh"

module command_shifter (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Filtered serial events
  input wire select_fall,
  input wire select_rise,
  input wire serial_clock_rise,
  input wire select_active,
  input wire serial_data,
  // Latched command
  output reg [`CMD_WIDTH-1:0] command_byte,
  output reg command_valid
);

  reg [`CMD_WIDTH-1:0] shift;
  reg [2:0] bit_count;
  reg byte_complete;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (rst) begin
      shift <= {`CMD_WIDTH{1'b0}};
      bit_count <= `BIT_COUNT_ZERO;
      byte_complete <= 1'b0;
      command_byte <= {`CMD_WIDTH{1'b0}};
      command_valid <= 1'b0;
    end else begin
      command_valid <= 1'b0;
      if (select_fall) begin
        // Frame start clears the shift path
        shift <= {`CMD_WIDTH{1'b0}};
        bit_count <= `BIT_COUNT_ZERO;
        byte_complete <= 1'b0;
      end else if (select_active && serial_clock_rise) begin
        shift <= {shift[`CMD_WIDTH-2:0], serial_data};
        bit_count <= bit_count + `BIT_COUNT_STEP;
        if (bit_count == `BIT_COUNT_LAST) begin
          // Last whole byte of the frame is the one applied
          command_byte <= {shift[`CMD_WIDTH-2:0], serial_data};
          byte_complete <= 1'b1;
        end
      end else if (select_rise) begin
        // Partial byte is dropped: nothing is applied without eight bits
        command_valid <= byte_complete;
        byte_complete <= 1'b0;
      end
    end
  end

endmodule // command_shifter
